// ===== rsd_pkg.sv
package rsd_pkg;
  localparam logic [7:0] CMD_SET_RUNTIME  = 8'h60;
  localparam logic [7:0] RESP_SUCCESS     = 8'h00;
  localparam int         REPORT_BYTES     = 64;
  localparam logic [5:0] BYTE_CMD         = 6'h00;
  localparam logic [5:0] BYTE_STATUS      = 6'h01;
  localparam logic [5:0] BYTE_REF         = 6'h05;
  localparam logic [5:0] BYTE_IRQ         = 6'h06;
  localparam logic [5:0] BYTE_ALTER       = 6'h07;
  localparam logic [5:0] BYTE_PIN0        = 6'h08;
  localparam logic [5:0] BYTE_LAST        = 6'h3f;
  localparam int         BIT_LOAD         = 7;
  localparam int         BIT_REF_SRC      = 0;
  localparam int         BIT_LVL_HI       = 2;
  localparam int         BIT_LVL_LO       = 1;
  localparam int         BIT_RISE_WE      = 4;
  localparam int         BIT_RISE_VAL     = 3;
  localparam int         BIT_FALL_WE      = 2;
  localparam int         BIT_FALL_VAL     = 1;
  localparam int         BIT_FLAG_CLR     = 0;
  localparam int         BIT_PIN_OUT      = 4;
  localparam int         BIT_PIN_DIR      = 3;
  localparam int         BIT_FN_HI        = 2;
  localparam logic [7:0] ALTER_YES        = 8'h01;
  localparam logic [1:0] RST_REF_LEVEL    = 2'h0;
  localparam logic       RST_REF_SRC      = 1'b0;
  localparam logic       RST_RISE_EN      = 1'b0;
  localparam logic       RST_FALL_EN      = 1'b0;
  localparam logic       RST_PIN_OUT      = 1'b0;
  localparam logic       RST_PIN_DIR      = 1'b1;
  typedef enum logic [1:0] {
    RSD_LVL_OFF  = 2'b00,
    RSD_LVL_1024 = 2'b01,
    RSD_LVL_2048 = 2'b10,
    RSD_LVL_4096 = 2'b11
  } rsd_level_t;
  typedef enum logic [2:0] {
    RSD_FN_GPIO    = 3'b000,
    RSD_FN_SUSPEND = 3'b001,
    RSD_FN_RX_LED  = 3'b010
  } rsd_fn_t;
  typedef enum logic [1:0] {
    RSD_ST_IDLE = 2'b00,
    RSD_ST_RECV = 2'b01,
    RSD_ST_RESP = 2'b11
  } rsd_state_t;
endpackage : rsd_pkg

// ===== rsd_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module rsd_edge_detect (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pin_async,
  input  wire logic rise_en,
  input  wire logic fall_en,
  input  wire logic flag_clr,
  output logic      flag
);
  logic [2:0] sync;
  logic       stable;
  logic       rise_seen;
  logic       fall_seen;
  logic       next_flag;

  // a change counts only once stages two and three agree
  assign rise_seen = sync[1] & sync[2] & ~stable;
  assign fall_seen = ~sync[1] & ~sync[2] & stable;
  // set wins over a clear in the same cycle
  assign next_flag = ((rise_seen & rise_en) | (fall_seen & fall_en))
                     | (flag & ~flag_clr);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync   <= 3'h0;
      stable <= 1'b0;
      flag   <= 1'b0;
    end else begin
      sync <= {sync[1:0], pin_async};
      if (sync[1] == sync[2]) begin
        stable <= sync[2];
      end
      flag <= next_flag;
    end
  end
endmodule : rsd_edge_detect
`default_nettype wire

// ===== rsd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - byte5 bit7 loads reference selection
// - byte5 bits2-1 pick reference level
// - byte5 bit0 picks reference source
// - byte6 bit7 gates detector changes
// - byte6 bit4 enables rising setting write
// - byte6 bit3 new rising setting
// - byte6 bit2 enables falling setting write
// - byte6 bit1 new falling setting
// - byte6 bit0 clears detection flag
// - byte7 one reloads pin settings
// - byte8 bit4 is output level
// - byte8 bit3 direction, gpio mode only
// - byte8 bits2-0 select pin function
// - decode only command code 0x60
// - settings volatile, default on reset
// - respond 0x60 then 0x00
module rsd_decoder (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_byte,
  input  wire logic               rx_last,
  input  wire logic               irq_pin,
  input  wire logic               pin_zero_in,
  input  wire logic               suspended,
  input  wire logic               rx_activity,
  output logic                    tx_valid,
  output logic [7:0]              tx_byte,
  output logic                    tx_last,
  output logic [1:0]              ref_level,
  output logic                    ref_internal,
  output logic                    rise_en,
  output logic                    fall_en,
  output logic                    irq_flag,
  output logic [2:0]              pin_zero_fn,
  output logic                    pin_zero_dir_in,
  output logic                    pin_zero_out_val,
  output logic                    pin_zero_out,
  output logic                    pin_zero_oe,
  output logic                    pin_zero_read
);
  import rsd_pkg::*;

  // one command-code test for the state machine and the frame flag
  function automatic logic is_set_cmd(input logic [7:0] b);
    return (b == CMD_SET_RUNTIME);
  endfunction : is_set_cmd

  // bytes 5 and 6 share the same load gate in their top bit
  function automatic logic load_gate(input logic [7:0] b);
    return b[BIT_LOAD];
  endfunction : load_gate

  rsd_state_t state;
  rsd_state_t next_state;
  logic [5:0] idx;
  logic       is_cmd;
  logic       alter;
  logic       resp_idx;
  logic       flag_clr;
  logic       pin_gpio;
  logic       next_out;
  logic       next_oe;
  logic [2:0] pad_sync;

  wire take      = (state == RSD_ST_RECV) && rx_valid;
  wire first_hit = (state == RSD_ST_IDLE) && rx_valid;
  wire at_ref    = take && is_cmd && (idx == BYTE_REF) && load_gate(rx_byte);
  wire at_irq    = take && is_cmd && (idx == BYTE_IRQ) && load_gate(rx_byte);
  wire at_alter  = take && is_cmd && (idx == BYTE_ALTER);
  wire at_pin    = take && is_cmd && (idx == BYTE_PIN0) && alter;
  // unknown function codes leave the pin as it is
  wire fn_legal  = rx_byte[BIT_FN_HI:0] <= RSD_FN_RX_LED;
  wire end_frame = rx_valid && (rx_last || idx == BYTE_LAST);

  assign flag_clr = at_irq && rx_byte[BIT_FLAG_CLR];
  assign pin_gpio = (pin_zero_fn == RSD_FN_GPIO);
  // direction only matters in gpio mode
  assign next_oe  = pin_gpio ? ~pin_zero_dir_in : 1'b1;
  always_comb begin
    unique case (pin_zero_fn)
      RSD_FN_SUSPEND: next_out = suspended;
      RSD_FN_RX_LED:  next_out = rx_activity;
      default:        next_out = pin_zero_out_val;
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      // a one-byte report carrying the code still gets its answer
      RSD_ST_IDLE: begin
        if (first_hit && !rx_last) begin
          next_state = RSD_ST_RECV;
        end else if (first_hit && is_set_cmd(rx_byte)) begin
          next_state = RSD_ST_RESP;
        end
      end
      // foreign reports are swallowed to their end, then dropped
      RSD_ST_RECV: begin
        if (end_frame) begin
          next_state = is_cmd ? RSD_ST_RESP : RSD_ST_IDLE;
        end
      end
      // bytes arriving while answering are not taken
      RSD_ST_RESP: begin
        if (resp_idx) begin
          next_state = RSD_ST_IDLE;
        end
      end
      default:     next_state = RSD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= RSD_ST_IDLE;
      idx   <= 6'h0;
      is_cmd <= 1'b0;
      alter <= 1'b0;
    end else begin
      state <= next_state;
      if (first_hit) begin
        idx    <= 6'h1;
        is_cmd <= is_set_cmd(rx_byte);
        alter  <= 1'b0;
      end else if (take) begin
        idx <= idx + 6'h1;
      end
      if (at_alter) alter <= (rx_byte == ALTER_YES);
    end
  end

  // response: two bytes, code echo then success
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      resp_idx <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      tx_last  <= 1'b0;
    end else begin
      tx_valid <= (next_state == RSD_ST_RESP);
      tx_byte  <= RESP_SUCCESS;
      tx_last  <= 1'b0;
      if (next_state == RSD_ST_RESP) begin
        resp_idx <= (state == RSD_ST_RESP);
        tx_byte  <= (state == RSD_ST_RESP) ? RESP_SUCCESS : CMD_SET_RUNTIME;
        tx_last  <= (state == RSD_ST_RESP);
      end else begin
        resp_idx <= 1'b0;
      end
    end
  end

  // runtime copies only; reset restores defaults
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ref_level        <= RST_REF_LEVEL;
      ref_internal     <= RST_REF_SRC;
      rise_en          <= RST_RISE_EN;
      fall_en          <= RST_FALL_EN;
      pin_zero_fn      <= RSD_FN_GPIO;
      pin_zero_dir_in  <= RST_PIN_DIR;
      pin_zero_out_val <= RST_PIN_OUT;
      pin_zero_out     <= RST_PIN_OUT;
      pin_zero_oe      <= 1'b0;
    end else begin
      if (at_ref) begin
        ref_level    <= rx_byte[BIT_LVL_HI:BIT_LVL_LO];
        ref_internal <= rx_byte[BIT_REF_SRC];
      end
      if (at_irq && rx_byte[BIT_RISE_WE]) rise_en <= rx_byte[BIT_RISE_VAL];
      if (at_irq && rx_byte[BIT_FALL_WE]) fall_en <= rx_byte[BIT_FALL_VAL];
      // bits 7-5 never read here
      if (at_pin && fn_legal) begin
        pin_zero_fn      <= rx_byte[BIT_FN_HI:0];
        pin_zero_dir_in  <= rx_byte[BIT_PIN_DIR];
        pin_zero_out_val <= rx_byte[BIT_PIN_OUT];
      end
      pin_zero_out  <= next_out;
      pin_zero_oe   <= next_oe;
    end
  end

  // pad is asynchronous; a level counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pad_sync      <= 3'h0;
      pin_zero_read <= 1'b0;
    end else begin
      pad_sync <= {pad_sync[1:0], pin_zero_in};
      if (pad_sync[1] == pad_sync[2]) begin
        pin_zero_read <= pad_sync[2];
      end
    end
  end

  rsd_edge_detect u_edge (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_async (irq_pin),
    .rise_en   (rise_en),
    .fall_en   (fall_en),
    .flag_clr  (flag_clr),
    .flag      (irq_flag)
  );
endmodule : rsd_decoder
`default_nettype wire

// ===== rsd_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rsd_decoder_checker (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_last,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_last,
  input wire logic [1:0] ref_level,
  input wire logic       ref_internal,
  input wire logic       rise_en,
  input wire logic       fall_en,
  input wire logic       irq_flag,
  input wire logic [2:0] pin_zero_fn,
  input wire logic       pin_zero_dir_in,
  input wire logic       pin_zero_out_val,
  input wire logic       pin_zero_out,
  input wire logic       pin_zero_oe
);
  logic [5:0] idx;
  logic       cmd_ok;
  logic       alter_ok;
  logic       clr_d;
  // byte 0 is judged before cmd_ok has been registered
  wire        hit = (idx == 6'h00) ? (rx_byte == 8'h60) : cmd_ok;
  wire        b5  = rx_valid && hit && idx == 6'h05;
  wire        b6  = rx_valid && hit && idx == 6'h06;
  wire        b8  = rx_valid && hit && idx == 6'h08 && alter_ok && rx_byte[2:0] < 3'h3;
  wire        clr = b6 && rx_byte[7] && rx_byte[0];
  always_ff @(posedge clk_sys) begin
    if (!reset_n || (rx_valid && (rx_last || idx == 6'h3f))) idx <= 6'h00;
    else if (rx_valid) idx <= idx + 6'h01;
    if (rx_valid && idx == 6'h00) cmd_ok <= rx_byte == 8'h60;
    if (rx_valid && idx == 6'h07) alter_ok <= rx_byte == 8'h01;
    clr_d <= clr;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_RESET_DEFAULTS: assert property ($rose(reset_n) |-> ref_level == 2'h0 && !ref_internal
    && !rise_en && !fall_en && !irq_flag && pin_zero_dir_in && !tx_valid) else $error("bad reset");
  AST_REF_LOAD: assert property (b5 && rx_byte[7] |=> ref_level == $past(rx_byte[2:1])
    && ref_internal == $past(rx_byte[0])) else $error("reference not loaded");
  AST_REF_KEEP: assert property (rx_valid && idx == 6'h05 && !(hit && rx_byte[7])
    |=> $stable({ref_level, ref_internal})) else $error("reference changed");
  AST_RISE_SET: assert property (b6 && rx_byte[7] && rx_byte[4] |=> rise_en == $past(rx_byte[3]))
    else $error("rising setting wrong");
  AST_FALL_SET: assert property (b6 && rx_byte[7] && rx_byte[2] |=> fall_en == $past(rx_byte[1]))
    else $error("falling setting wrong");
  AST_EDGE_KEEP: assert property (rx_valid && idx == 6'h06 && !(hit && rx_byte[7])
    |=> $stable({rise_en, fall_en})) else $error("edge settings changed");
  AST_FLAG_STICKY: assert property (irq_flag && !clr && !clr_d |=> irq_flag)
    else $error("flag dropped");
  AST_PIN_LOAD: assert property (b8 |=> pin_zero_fn == $past(rx_byte[2:0])
    && pin_zero_out_val == $past(rx_byte[4])) else $error("pin not loaded");
  AST_PIN_KEEP: assert property (rx_valid && idx == 6'h08 && !b8
    |=> $stable({pin_zero_fn, pin_zero_dir_in, pin_zero_out_val})) else $error("pin changed");
  AST_GPIO_DRIVE: assert property (pin_zero_fn == 3'h0 && !pin_zero_dir_in
    |=> pin_zero_oe && pin_zero_out == $past(pin_zero_out_val)) else $error("pad not driven");
  AST_RESP_PAIR: assert property (tx_valid && !tx_last |-> tx_byte == 8'h60
    ##1 tx_valid && tx_last && tx_byte == 8'h00 ##1 !tx_valid) else $error("bad response");
  AST_RESP_CAUSE: assert property (rx_valid && (rx_last || idx == 6'h3f)
    |=> tx_valid == $past(hit)) else $error("response mismatch");
endmodule : rsd_decoder_checker
`default_nettype wire

// ===== rsd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsd_host_model (
  input  wire logic       clk_sys,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid = 1'b0,
  output logic [7:0]      rx_byte = 8'h00,
  output logic            rx_last = 1'b0
);
  // msg is {code, byte5, byte6, byte7, byte8}; bytes 1-4 are filler
  task automatic send_report(input logic [39:0] msg, output int n, output logic [15:0] resp);
    logic [7:0] b;
    n = 0;
    resp = 16'h0000;
    for (int i = 0; i < 9; i++) begin
      b = (i == 0) ? msg[39:32] : (i < 5) ? 8'h5a : msg[8*(8-i) +: 8];
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_byte  <= b;
      rx_last  <= i == 8;
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_byte  <= ~b;
    repeat (4) begin
      @(posedge clk_sys);
      if (tx_valid === 1'b1) begin
        resp = {resp[7:0], tx_byte};
        n++;
      end
    end
  endtask : send_report
endmodule : rsd_host_model
`default_nettype wire

// ===== runtime_settings_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module runtime_settings_command_decoder_tb;
  import rsd_pkg::*;
  typedef struct packed {logic [39:0] msg; logic [9:0] exp;} rsd_row_t;
  logic clk_sys = 1'b0, reset_n = 1'b0, irq_pin = 1'b0, pin_zero_in = 1'b0;
  logic suspended = 1'b0, rx_activity = 1'b0, rx_valid, rx_last, tx_valid, tx_last;
  logic ref_internal, rise_en, fall_en, irq_flag, pin_zero_dir_in, pin_zero_out_val;
  logic pin_zero_out, pin_zero_oe, pin_zero_read;
  logic [7:0] rx_byte, tx_byte;
  logic [1:0] ref_level;
  logic [2:0] pin_zero_fn;
  logic [15:0] resp;
  int fail_count = 0, compares = 0, n;
  wire logic [9:0] cfg = {ref_level, ref_internal, rise_en, fall_en, pin_zero_fn,
                          pin_zero_dir_in, pin_zero_out_val};
  rsd_row_t rows [7] = '{'{40'h6085980110, 10'h2c1}, '{40'h6007860009, 10'h2e1},
    '{40'h55879e0101, 10'h2e1}, '{40'h60fe1a01e9, 10'h366}, '{40'h6083940102, 10'h188},
    '{40'h608000010c, 10'h008}, '{40'h6002000210, 10'h008}};
  rsd_decoder u_rsd_decoder (
    .clk_sys(clk_sys), .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_last(rx_last), .irq_pin(irq_pin), .pin_zero_in(pin_zero_in), .suspended(suspended),
    .rx_activity(rx_activity), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .ref_level(ref_level), .ref_internal(ref_internal), .rise_en(rise_en), .fall_en(fall_en),
    .irq_flag(irq_flag), .pin_zero_fn(pin_zero_fn), .pin_zero_dir_in(pin_zero_dir_in),
    .pin_zero_out_val(pin_zero_out_val), .pin_zero_out(pin_zero_out),
    .pin_zero_oe(pin_zero_oe), .pin_zero_read(pin_zero_read));
  rsd_host_model u_rsd_host_model (
    .clk_sys(clk_sys), .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_last(rx_last));
  always #20 clk_sys = ~clk_sys;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic send(input logic [39:0] msg);
    u_rsd_host_model.send_report(msg, n, resp);
  endtask : send
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      send(rows[i].msg);
      check(16'(n), (rows[i].msg[39:32] == CMD_SET_RUNTIME) ? 16'h0002 : 16'h0000);
      check(resp, (n == 2) ? {CMD_SET_RUNTIME, RESP_SUCCESS} : 16'h0000);
      check({6'h00, cfg}, {6'h00, rows[i].exp});
      $display("row %0d done", i);
    end
    // sticky flag: rise on, edge, then clear with rise off
    send(40'h6000980000);
    irq_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    irq_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check({15'h0000, irq_flag}, 16'h0001);
    send(40'h6000910000);
    check({15'h0000, irq_flag}, 16'h0000);
    irq_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check({15'h0000, irq_flag}, 16'h0000);
    $display("flag test done");
    send(40'h6000000110);
    pin_zero_in <= 1'b1;
    // pad sample passes a three-stage synchroniser
    repeat (6) @(posedge clk_sys);
    check({13'h0000, pin_zero_oe, pin_zero_out, pin_zero_read}, 16'h0007);
    send(40'h6000000118);
    check({15'h0000, pin_zero_oe}, 16'h0000);
    send(40'h6000000109);
    suspended <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({14'h0000, pin_zero_oe, pin_zero_out}, 16'h0003);
    send(40'h600000011a);
    check({14'h0000, pin_zero_oe, pin_zero_out}, 16'h0002);
    rx_activity <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({14'h0000, pin_zero_oe, pin_zero_out}, 16'h0003);
    $display("pad test done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    check({5'h00, irq_flag, cfg}, 16'h0002);
    $display("reset test done");
    give_verdict();
  end
endmodule : runtime_settings_command_decoder_tb
bind rsd_decoder rsd_decoder_checker u_rsd_decoder_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
  .rx_last(rx_last), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
  .ref_level(ref_level), .ref_internal(ref_internal), .rise_en(rise_en), .fall_en(fall_en),
  .irq_flag(irq_flag), .pin_zero_fn(pin_zero_fn), .pin_zero_dir_in(pin_zero_dir_in),
  .pin_zero_out_val(pin_zero_out_val), .pin_zero_out(pin_zero_out), .pin_zero_oe(pin_zero_oe));
`default_nettype wire
